/* File: core/motor_io_defs.vh */
// Contract
// - two-wire: run while exactly one of cw, ccw on
// - stop-method input picks decel or instant stop
// - two select bits pick one of four
// - four select bits pick one of sixteen
// - alarm clear resets the active alarm
// - three-wire: run only with start and gate
// - three-wire: start off decelerates to stop
// - three-wire: gate off stops instantly
// - three-wire: direction input sets rotation way
// - hold release switches holding at standstill
// - torque cap input enables torque limiting
// - notice clear clears the notice condition
// - panel lock restricts panel and software operations
// - fault input low raises alarm, forced stop
// - thirty speed pulses per shaft revolution
// - alarm output low while protective alarm active
// - moving output while running from run input
// - notice output while notice condition present
// - torque hit output when torque at limit
// - speed reached within width of set speed
// - direction output reports rotation direction
// - input on when current flows through it
// - per-terminal polarity, one inverts, reset zero
// - two-wire: both run inputs on decelerates; code follows stop-method input, instant stop when it is on
// - data number is binary of select bits
// - alarm clear ignored while running inputs on
// - unassigned lock, cap, fault read on; and-ed
`ifndef MOTOR_IO_DEFS_VH
`define MOTOR_IO_DEFS_VH
// register byte offsets
`define OFS_POLARITY   12'h000
`define OFS_IN_ASSIGN0 12'h004
`define OFS_IN_ASSIGN1 12'h008
`define OFS_OUT_ASSIGN 12'h00c
`define OFS_CONTROL    12'h010
`define OFS_STATUS     12'h014
`define OFS_MOTOR_FB   12'h018
// input function codes, 4 bits
`define FN_NONE    4'h0
`define FN_CW      4'h1
`define FN_CCW     4'h2
`define FN_STOPSEL 4'h3
`define FN_SEL0    4'h4
`define FN_SEL1    4'h5
`define FN_ACLR    4'h6
`define FN_START   4'h7
`define FN_GATE    4'h8
`define FN_DIRSEL  4'h9
`define FN_SEL2    4'ha
`define FN_SEL3    4'hb
`define FN_HOLDREL 4'hc
`define FN_TCAP    4'hd
`define FN_NCLR    4'he
`define FN_PLOCK   4'hf
`define FN_XFAULT  4'h0
// external fault shares code zero; live only with fault enable set
// output function codes, 3 bits
`define OF_SPEED   3'h0
`define OF_ALARM   3'h1
`define OF_MOVE    3'h2
`define OF_NOTICE  3'h3
`define OF_TCHIT   3'h4
`define OF_VREACH  3'h5
`define OF_DIR     3'h6
// factory assignment, terminal 0 in low nibble
`define IN_ASSIGN0_RST 16'h4321
`define IN_ASSIGN1_RST 12'h065
`define OUT_ASSIGN_RST 6'h08
`define POLARITY_RST   7'h00
// control fields
`define CTL_RST        8'h00
`define CTL_THREEWIRE  0
`define CTL_DIRINV     1
`define CTL_FAULT_EN   2
`define CTL_NOTICE     3
// speed pulse: 30 per rev, pulse 0.2 ms
`define PULSES_PER_REV 8'd30
`define PULSE_US       200
`define CLK_MHZ        125
`define US_DIV_LAST    7'h7c // clocks per microsecond, minus one
`define PULSE_US_LOAD  8'hc8 // pulse width in microseconds
// terminal count
`define NUM_TERMINALS  7
`endif

/* File: core/motor_driver_io_control.v */
`timescale 1ns/100ps
`default_nettype none
`include "motor_io_defs.vh"
module motor_driver_io_control (
    // clock and reset
    input  wire        clk,
    input  wire        rstn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // terminals, on when current flows
    input  wire [6:0]  inputTerminal,
    output reg         outputTerminal0,
    output reg         outputTerminal1,
    // motor core feedback
    input  wire        rotating,
    input  wire        motorCcw,
    input  wire        revTick,
    input  wire        protectAlarm,
    input  wire        noticeCause,
    input  wire        torqueAtCap,
    input  wire [15:0] speedMeas,
    input  wire [15:0] speedSet,
    // motor core commands
    output reg         runCmd,
    output reg         ccwCmd,
    output reg         decelStop,
    output reg         instantStop,
    output reg  [3:0]  dataNumber,
    output reg         holdRelease,
    output reg         torqueCapOn,
    output reg         panelLock,
    output reg         alarmActive,
    output reg         noticeActive
);
    // reset synchroniser
    reg rs1Reg, rstSyncReg;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rs1Reg     <= 1'b0;
            rstSyncReg <= 1'b0;
        end else begin
            rs1Reg     <= 1'b1;
            rstSyncReg <= rs1Reg;
        end
    end
    wire rst = ~rstSyncReg;

    // registers
    reg [6:0]  polarityReg;
    reg [27:0] inAssignReg;
    reg [5:0]  outAssignReg;
    reg [7:0]  controlReg;
    reg [15:0] widthReg;
    reg        aclrPulse, nclrPulse;
    wire       wrEn = psel & penable & pwrite;
    wire       rdEn = psel & ~penable & ~pwrite;

    // bus response: zero wait, never an error; low only in reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end
    end

    // status word write, decoded for both clear strobes
    function statusWrite;
        input        en;
        input [11:0] addr;
        begin
            statusWrite = en & (addr == `OFS_STATUS);
        end
    endfunction

    // write path
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            polarityReg  <= `POLARITY_RST;
            inAssignReg  <= {`IN_ASSIGN1_RST, `IN_ASSIGN0_RST};
            outAssignReg <= `OUT_ASSIGN_RST;
            controlReg   <= `CTL_RST;
            widthReg     <= 16'h0000;
        end else if (wrEn) begin
            case (paddr)
                `OFS_POLARITY:   polarityReg  <= pwdata[6:0];
                `OFS_IN_ASSIGN0: inAssignReg[15:0] <= pwdata[15:0];
                `OFS_IN_ASSIGN1: inAssignReg[27:16] <= pwdata[11:0];
                `OFS_OUT_ASSIGN: outAssignReg <= pwdata[5:0];
                `OFS_CONTROL:    controlReg   <= pwdata[7:0];
                `OFS_MOTOR_FB:   widthReg     <= pwdata[15:0];
                default:         ;
            endcase
        end
    end

    // input sync and polarity
    reg [6:0] sync1Reg, sync2Reg, termOnReg;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1Reg  <= 7'h00;
            sync2Reg  <= 7'h00;
            termOnReg <= 7'h00;
        end else begin
            sync1Reg  <= inputTerminal;
            sync2Reg  <= sync1Reg;
            termOnReg <= sync2Reg ^ polarityReg;
        end
    end

    // per function: any assigned, all assigned on
    function [1:0] fnState;
        input [3:0]  code;
        input        useFault;
        input [27:0] asgTab;
        input [6:0]  on;
        input [7:0]  ctl;
        integer k;
        reg any, all;
        begin
            any = 1'b0;
            all = 1'b1;
            for (k = 0; k < `NUM_TERMINALS; k = k + 1) begin
                if (asgTab[k*4 +: 4] == code && (useFault == 1'b0 || ctl[`CTL_FAULT_EN])) begin
                    any = 1'b1;
                    all = all & on[k];
                end
            end
            fnState = {any, any & all};
        end
    endfunction

    // run, select and switch functions
    wire [1:0] fCw   = fnState(`FN_CW, 1'b0, inAssignReg, termOnReg, 8'h00);
    wire [1:0] fCcw  = fnState(`FN_CCW, 1'b0, inAssignReg, termOnReg, 8'h00);
    wire [1:0] fStop = fnState(`FN_STOPSEL, 1'b0, inAssignReg, termOnReg, 8'h00);
    wire [1:0] fS0   = fnState(`FN_SEL0, 1'b0, inAssignReg, termOnReg, 8'h00);
    wire [1:0] fS1   = fnState(`FN_SEL1, 1'b0, inAssignReg, termOnReg, 8'h00);
    wire [1:0] fS2   = fnState(`FN_SEL2, 1'b0, inAssignReg, termOnReg, 8'h00);
    wire [1:0] fS3   = fnState(`FN_SEL3, 1'b0, inAssignReg, termOnReg, 8'h00);
    wire [1:0] fAclr = fnState(`FN_ACLR, 1'b0, inAssignReg, termOnReg, 8'h00);
    wire [1:0] fSt   = fnState(`FN_START, 1'b0, inAssignReg, termOnReg, 8'h00);
    wire [1:0] fGate = fnState(`FN_GATE, 1'b0, inAssignReg, termOnReg, 8'h00);
    wire [1:0] fDir  = fnState(`FN_DIRSEL, 1'b0, inAssignReg, termOnReg, 8'h00);
    wire [1:0] fHold = fnState(`FN_HOLDREL, 1'b0, inAssignReg, termOnReg, 8'h00);
    wire [1:0] fCap  = fnState(`FN_TCAP, 1'b0, inAssignReg, termOnReg, 8'h00);
    wire [1:0] fNclr = fnState(`FN_NCLR, 1'b0, inAssignReg, termOnReg, 8'h00);
    wire [1:0] fLock = fnState(`FN_PLOCK, 1'b0, inAssignReg, termOnReg, 8'h00);

    // external fault: terminals coded zero, live only with fault enable
    wire [1:0] fXf   = fnState(`FN_XFAULT, 1'b1, inAssignReg, termOnReg, controlReg);

    wire threeWire = controlReg[`CTL_THREEWIRE];
    wire cwOn   = fCw[0];
    wire ccwOn  = fCcw[0];
    wire stOn   = fSt[0];
    wire gateOn = fGate[0];
    // unassigned reads on
    wire capOn  = fCap[0] | ~fCap[1];
    wire lockOn = fLock[0] | ~fLock[1];
    wire xfOn   = fXf[0] | ~fXf[1];
    wire runInputs = threeWire ? (stOn & gateOn) : (cwOn | ccwOn);

    // run decode and stop method
    reg runNext, ccwNext, decelNext, instNext;
    always @* begin
        runNext   = 1'b0;
        ccwNext   = ccwCmd;
        decelNext = 1'b0;
        instNext  = 1'b0;
        if (threeWire) begin
            runNext = stOn & gateOn;
            ccwNext = fDir[0];
            instNext  = ~gateOn;
            decelNext = gateOn & ~stOn;
        end else begin
            runNext = cwOn ^ ccwOn;
            if (runNext)
                ccwNext = ccwOn ^ controlReg[`CTL_DIRINV];
            instNext  = ~runNext & fStop[0];
            decelNext = ~runNext & ~fStop[0];
        end
        if (alarmActive) begin
            runNext   = 1'b0;
            decelNext = 1'b0;
            instNext  = 1'b1;
        end
    end

    // alarm and notice state
    wire aclrAccept = fAclr[0] & ~runInputs;
    wire nclrReq    = fNclr[0] | nclrPulse;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            alarmActive  <= 1'b0;
            noticeActive <= 1'b0;
        end else begin
            if (protectAlarm | ~xfOn)
                alarmActive <= 1'b1; // set wins over clear
            else if (aclrAccept | aclrPulse)
                alarmActive <= 1'b0;
            if (noticeCause)
                noticeActive <= 1'b1; // set wins
            else if (nclrReq | ~controlReg[`CTL_NOTICE])
                noticeActive <= 1'b0;
        end
    end

    // command outputs
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            runCmd      <= 1'b0;
            ccwCmd      <= 1'b0;
            decelStop   <= 1'b0;
            instantStop <= 1'b1;
            dataNumber  <= 4'h0;
            holdRelease <= 1'b0;
            torqueCapOn <= 1'b1;
            panelLock   <= 1'b1;
        end else begin
            runCmd      <= runNext;
            ccwCmd      <= ccwNext;
            decelStop   <= decelNext;
            instantStop <= instNext;
            if (fS2[1] | fS3[1])
                dataNumber <= {fS3[0], fS2[0], fS1[0], fS0[0]};
            else
                dataNumber <= {2'b00, fS1[0], fS0[0]};
            if (~rotating)
                holdRelease <= fHold[0];
            torqueCapOn <= capOn;
            panelLock   <= ~lockOn;
        end
    end

    // microsecond enable from a free-running divider
    // keeps the pulse timer at 8 bits instead of 15
    reg [6:0] usDivReg;
    reg       usTickReg;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            usDivReg  <= 7'h00;
            usTickReg <= 1'b0;
        end else if (usDivReg == `US_DIV_LAST) begin
            usDivReg  <= 7'h00;
            usTickReg <= 1'b1;
        end else begin
            usDivReg  <= usDivReg + 7'h01;
            usTickReg <= 1'b0;
        end
    end

    // speed pulse: revTick marks 1/30 rev steps, held 0.2 ms
    reg [7:0] pulseCnt;
    reg       speedPulse;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pulseCnt   <= 8'h00;
            speedPulse <= 1'b0;
        end else if (revTick) begin
            pulseCnt   <= `PULSE_US_LOAD;
            speedPulse <= 1'b1;
        end else if (pulseCnt != 8'h00) begin
            if (usTickReg)
                pulseCnt <= pulseCnt - 8'h01;
        end else begin
            speedPulse <= 1'b0;
        end
    end

    // speed reached window
    wire [16:0] diff = (speedMeas > speedSet) ? {1'b0, speedMeas - speedSet}
                                              : {1'b0, speedSet - speedMeas};
    wire vReach = runCmd & (diff <= {1'b0, widthReg});

    // output selection
    function outSel;
        input [2:0] code;
        input [6:0] src;
        begin
            case (code)
                `OF_SPEED:  outSel = src[0];
                `OF_ALARM:  outSel = src[1];
                `OF_MOVE:   outSel = src[2];
                `OF_NOTICE: outSel = src[3];
                `OF_TCHIT:  outSel = src[4];
                `OF_VREACH: outSel = src[5];
                `OF_DIR:    outSel = src[6];
                default:    outSel = 1'b0;
            endcase
        end
    endfunction
    wire [6:0] outSrc = {motorCcw,
                         vReach,
                         torqueAtCap & torqueCapOn,
                         noticeActive,
                         rotating & runCmd,
                         ~alarmActive,
                         speedPulse};
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            outputTerminal0 <= 1'b0;
            outputTerminal1 <= 1'b0;
        end else begin
            outputTerminal0 <= outSel(outAssignReg[2:0], outSrc);
            outputTerminal1 <= outSel(outAssignReg[5:3], outSrc);
        end
    end

    // read path, data valid in access phase
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata    <= 32'h00000000;
            aclrPulse <= 1'b0;
            nclrPulse <= 1'b0;
        end else begin
            aclrPulse <= statusWrite(wrEn, paddr) & pwdata[0] & ~runInputs;
            nclrPulse <= statusWrite(wrEn, paddr) & pwdata[1];
            if (rdEn) begin
                case (paddr)
                    `OFS_POLARITY:   prdata <= {25'h0, polarityReg};
                    `OFS_IN_ASSIGN0: prdata <= {16'h0, inAssignReg[15:0]};
                    `OFS_IN_ASSIGN1: prdata <= {20'h0, inAssignReg[27:16]};
                    `OFS_OUT_ASSIGN: prdata <= {26'h0, outAssignReg};
                    `OFS_CONTROL:    prdata <= {24'h0, controlReg};
                    `OFS_STATUS:     prdata <= {16'h0, dataNumber, termOnReg[6:0], runCmd,
                                                ccwCmd, panelLock, noticeActive, alarmActive};
                    `OFS_MOTOR_FB:   prdata <= {16'h0, widthReg};
                    default:         prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // motor_driver_io_control
`default_nettype wire

/* File: test/motor_io_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module motor_io_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // motor core feedback
    input wire logic protectAlarm,
    input wire logic noticeCause,
    input wire logic revTick,
    // decoded state and terminals
    input wire logic alarmActive,
    input wire logic noticeActive,
    input wire logic runCmd,
    input wire logic instantStop,
    input wire logic torqueCapOn,
    input wire logic panelLock,
    input wire logic outputTerminal0,
    input wire logic outputTerminal1
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // cycles since reset release, saturating
    logic [1:0] upCnt;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            upCnt <= 2'd0;
        end else if (upCnt != 2'd3) begin
            upCnt <= upCnt + 2'd1;
        end
    end
    // alarm raised, then reported
    sequence s_alarmUp;
        $rose(protectAlarm) ##[1:4] alarmActive;
    endsequence
    // notice cause gone for a while
    sequence s_quiet;
        !noticeCause [*6];
    endsequence
    property p_alarm_set;
        $rose(protectAlarm) |-> ##[1:4] alarmActive;
    endproperty
    property p_alarm_stop;
        s_alarmUp |-> ##[0:2] (instantStop && !runCmd);
    endproperty
    property p_alarm_hold;
        alarmActive [*3] |-> !runCmd;
    endproperty
    property p_alarm_out;
        alarmActive [*3] |-> !outputTerminal1;
    endproperty
    property p_notice_set;
        $rose(noticeCause) |-> ##[1:4] noticeActive;
    endproperty
    property p_notice_clr;
        s_quiet |-> !noticeActive;
    endproperty
    property p_pulse;
        $rose(revTick) |-> ##[1:4] outputTerminal0;
    endproperty
    property p_unassigned;
        (upCnt == 2'd2) |=> (torqueCapOn && !panelLock);
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm not raised");
    a_alarm_stop: assert property (p_alarm_stop) else $error("alarm without stop");
    a_alarm_hold: assert property (p_alarm_hold) else $error("run during alarm");
    a_alarm_out: assert property (p_alarm_out) else $error("alarm output high");
    a_notice_set: assert property (p_notice_set) else $error("notice not raised");
    a_notice_clr: assert property (p_notice_clr) else $error("notice stuck");
    a_pulse: assert property (p_pulse) else $error("no speed pulse");
    a_unassigned: assert property (p_unassigned) else $error("unassigned not on");
endmodule // motor_io_chk
bind motor_driver_io_control motor_io_chk u_chk (.clk(clk), .rstn(rstn),
    .protectAlarm(protectAlarm), .noticeCause(noticeCause), .revTick(revTick),
    .alarmActive(alarmActive), .noticeActive(noticeActive), .runCmd(runCmd),
    .instantStop(instantStop), .torqueCapOn(torqueCapOn), .panelLock(panelLock),
    .outputTerminal0(outputTerminal0), .outputTerminal1(outputTerminal1));
`default_nettype wire

/* File: test/io_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module io_host_model (
    // clock and requested levels
    input wire logic       clk,
    input wire logic [6:0] want,
    // terminal currents
    output var logic [6:0] inputTerminal
);
    initial inputTerminal = 7'h00;
    // current flows exactly on terminals asked on
    always @(posedge clk) begin
        inputTerminal <= want;
    end
endmodule // io_host_model
`default_nettype wire

/* File: test/motor_driver_io_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "motor_io_defs.vh"
module motor_driver_io_control_tb;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic        revTick, protectAlarm, noticeCause, output_terminal_0, output_terminal_1, runCmd, ccwCmd;
    logic        decelStop, instantStop, holdRelease, torqueCapOn, panelLock;
    logic        alarmActive, noticeActive;
    logic        rotating, motorCcw, torqueAtCap;
    logic [15:0] speedMeas, speedSet;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  dataNumber;
    logic [6:0]  want, term;
    int          mismatches, checksDone, cycles;
    // host side terminal driver
    io_host_model u_host (.clk(clk), .want(want), .inputTerminal(term));
    motor_driver_io_control u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .inputTerminal(term), .outputTerminal0(output_terminal_0),
        .outputTerminal1(output_terminal_1), .rotating(rotating), .motorCcw(motorCcw), .revTick(revTick),
        .protectAlarm(protectAlarm), .noticeCause(noticeCause), .torqueAtCap(torqueAtCap),
        .speedMeas(speedMeas), .speedSet(speedSet), .runCmd(runCmd), .ccwCmd(ccwCmd),
        .decelStop(decelStop), .instantStop(instantStop), .dataNumber(dataNumber),
        .holdRelease(holdRelease), .torqueCapOn(torqueCapOn), .panelLock(panelLock),
        .alarmActive(alarmActive), .noticeActive(noticeActive));
    // final report
    task wrapUp;
        $display("mismatches=%0d checks=%0d", mismatches, checksDone);
        if (mismatches == 0 && checksDone > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chkBit(input logic got, input logic exp);
        checksDone++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask
    task chkWord(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: value %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task rdChk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chkWord(rd, exp);
    endtask
    // terminal change, then settle past sync latency
    task setTerm(input logic [6:0] v);
        want <= v;
        repeat (8) @(posedge clk);
    endtask
    task regsScenario;
        rdChk(`OFS_POLARITY, 32'h0);
        rdChk(`OFS_IN_ASSIGN0, 32'h4321);
        rdChk(`OFS_IN_ASSIGN1, 32'h065);
        apb(1'b1, `OFS_POLARITY, 32'h7f);
        rdChk(`OFS_POLARITY, 32'h7f);
        apb(1'b1, 12'h100, 32'h1);
        rdChk(12'h100, 32'h0);
        apb(1'b1, `OFS_POLARITY, 32'h0);
    endtask
    task twoWireScenario;
        setTerm(7'h01);
        chkBit(runCmd, 1'b1);
        chkBit(ccwCmd, 1'b0);
        setTerm(7'h00);
        chkBit(decelStop, 1'b1);
        setTerm(7'h02);
        chkBit(ccwCmd, 1'b1);
        setTerm(7'h03);
        chkBit(runCmd, 1'b0);
        chkBit(decelStop, 1'b1);
        setTerm(7'h05);
        setTerm(7'h04);
        chkBit(instantStop, 1'b1);
        apb(1'b1, `OFS_CONTROL, 32'h2);
        setTerm(7'h01);
        chkBit(ccwCmd, 1'b1);
        apb(1'b1, `OFS_CONTROL, 32'h0);
        setTerm(7'h00);
    endtask
    task selectScenario;
        int n;
        for (n = 0; n < 4; n++) begin
            setTerm({2'b00, n[1], n[0], 3'b000});
            chkWord({28'h0, dataNumber}, n);
        end
        apb(1'b1, `OFS_IN_ASSIGN0, 32'h4a21);
        apb(1'b1, `OFS_IN_ASSIGN1, 32'hb65);
        for (n = 0; n < 16; n++) begin
            setTerm({n[3], 1'b0, n[1], n[0], n[2], 2'b00});
            chkWord({28'h0, dataNumber}, n);
        end
        apb(1'b1, `OFS_IN_ASSIGN0, 32'h4321);
        apb(1'b1, `OFS_IN_ASSIGN1, 32'h065);
        setTerm(7'h00);
    endtask
    task polarityScenario;
        apb(1'b1, `OFS_POLARITY, 32'h01);
        setTerm(7'h00);
        chkBit(runCmd, 1'b1);
        apb(1'b1, `OFS_POLARITY, 32'h0);
        setTerm(7'h00);
        chkBit(runCmd, 1'b0);
    endtask
    task alarmScenario;
        protectAlarm <= 1'b1;
        noticeCause <= 1'b1;
        revTick <= 1'b1;
        @(posedge clk);
        revTick <= 1'b0;
        setTerm(7'h21);
        chkBit(alarmActive, 1'b1);
        chkBit(output_terminal_1, 1'b0);
        chkBit(runCmd, 1'b0);
        chkBit(instantStop, 1'b1);
        chkBit(noticeActive, 1'b1);
        chkBit(output_terminal_0, 1'b1);
        protectAlarm <= 1'b0;
        noticeCause <= 1'b0;
        setTerm(7'h21);
        chkBit(alarmActive, 1'b1);
        chkBit(noticeActive, 1'b0);
        setTerm(7'h00);
        setTerm(7'h20);
        chkBit(alarmActive, 1'b0);
        chkBit(output_terminal_1, 1'b1);
        setTerm(7'h00);
        apb(1'b1, `OFS_CONTROL, 32'h4);
        setTerm(7'h00);
        chkBit(alarmActive, 1'b1);
        chkBit(instantStop, 1'b1);
        setTerm(7'h40);
        chkBit(alarmActive, 1'b1);
        apb(1'b1, `OFS_STATUS, 32'h1);
        setTerm(7'h40);
        chkBit(alarmActive, 1'b0);
        apb(1'b1, `OFS_CONTROL, 32'h0);
        setTerm(7'h00);
    endtask
    task threeWireScenario;
        apb(1'b1, `OFS_IN_ASSIGN0, 32'h4987);
        apb(1'b1, `OFS_CONTROL, 32'h1);
        setTerm(7'h03);
        chkBit(runCmd, 1'b1);
        chkBit(ccwCmd, 1'b0);
        setTerm(7'h07);
        chkBit(ccwCmd, 1'b1);
        setTerm(7'h02);
        chkBit(runCmd, 1'b0);
        chkBit(decelStop, 1'b1);
        setTerm(7'h03);
        setTerm(7'h01);
        chkBit(runCmd, 1'b0);
        chkBit(instantStop, 1'b1);
        apb(1'b1, `OFS_CONTROL, 32'h0);
        apb(1'b1, `OFS_IN_ASSIGN0, 32'h4321);
    endtask
    task outputsScenario;
        apb(1'b1, `OFS_OUT_ASSIGN, 32'h22);
        rotating <= 1'b1;
        torqueAtCap <= 1'b1;
        setTerm(7'h01);
        chkBit(output_terminal_0, 1'b1);
        chkBit(output_terminal_1, 1'b1);
        apb(1'b1, `OFS_IN_ASSIGN1, 32'hc65);
        setTerm(7'h41);
        chkBit(holdRelease, 1'b0);
        rotating <= 1'b0;
        setTerm(7'h41);
        chkBit(holdRelease, 1'b1);
        chkBit(output_terminal_0, 1'b0);
        apb(1'b1, `OFS_OUT_ASSIGN, 32'h35);
        apb(1'b1, `OFS_MOTOR_FB, 32'h5);
        speedSet <= 16'h0064;
        speedMeas <= 16'h005f;
        motorCcw <= 1'b1;
        setTerm(7'h01);
        chkBit(output_terminal_0, 1'b1);
        chkBit(output_terminal_1, 1'b1);
        speedMeas <= 16'h006e;
        motorCcw <= 1'b0;
        setTerm(7'h01);
        chkBit(output_terminal_0, 1'b0);
        chkBit(output_terminal_1, 1'b0);
        apb(1'b1, `OFS_IN_ASSIGN1, 32'hd65);
        setTerm(7'h00);
        chkBit(torqueCapOn, 1'b0);
        setTerm(7'h40);
        chkBit(torqueCapOn, 1'b1);
        apb(1'b1, `OFS_IN_ASSIGN1, 32'hff5);
        setTerm(7'h40);
        chkBit(panelLock, 1'b1);
        setTerm(7'h60);
        chkBit(panelLock, 1'b0);
        apb(1'b1, `OFS_IN_ASSIGN1, 32'h065);
        apb(1'b1, `OFS_OUT_ASSIGN, 32'h08);
        torqueAtCap <= 1'b0;
        setTerm(7'h00);
        chkBit(torqueCapOn, 1'b1);
        chkBit(panelLock, 1'b0);
    endtask
    // free running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            wrapUp();
        end
    end
    // main sequence
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        want = 7'h00;
        revTick = 1'b0;
        protectAlarm = 1'b0;
        noticeCause = 1'b0;
        rotating = 1'b0;
        motorCcw = 1'b0;
        torqueAtCap = 1'b0;
        speedMeas = 16'h0000;
        speedSet = 16'h0000;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        regsScenario();
        twoWireScenario();
        selectScenario();
        polarityScenario();
        alarmScenario();
        threeWireScenario();
        outputsScenario();
        wrapUp();
    end
endmodule // motor_driver_io_control_tb
`default_nettype wire
